// File: tcnf_capture.v
/*
 * capture and compare register set of one timer subblock, with the noise
 * canceller on the first input, behind an axi4-lite slave.
 * assumes: counters and their upcount ticks come from the surrounding timer
 * on core_clk; the input pin is asynchronous; one clock, synchronous reset
 * (also driven by hardware standby entry).
 */
`timescale 1ns/1ps
`default_nettype none
`include "tcnf_map.vh"
module tcnf_capture #(
    parameter SUBBLOCK = 12, // subblock index; register d only on 12..15
    parameter NC_WIDTH = 8
) (
    input wire core_clk,
    input wire rst,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // timer side
    input wire first_timer_input,
    input wire noise_tick,
    input wire [23:0] time_counter_a,
    input wire [15:0] edge_event_counter,
    input wire [23:0] time_counter_c,
    input wire tca_up_tick,
    input wire tcc_up_tick,
    input wire cap_a_strobe,
    input wire cap_b_strobe,
    input wire evb_match_b,
    input wire dma_readout_rd,
    output wire filtered_input,
    output reg input_capture_flag,
    output reg timer_master_enable
);
    // register state
    reg [23:0] cca_r; // register a, 24 significant bits
    reg [15:0] ccb_r;
    reg [23:0] ccc_r;
    reg [23:0] ccd_r;
    reg [31:0] rdo_r; // readout shadow, never read or written; the readout shows TCNF_RST_RDO until rdo_live_r is set
    reg rdo_live_r; // cleared readout shadow once any capture or any bus write runs
    reg [7:0] nlim_r;
    reg [2:0] mode_r;
    reg nce_r;
    reg ncm_r;
    reg ccc_pend_r; // capture c waits for the next counter c tick
    reg ccd_pend_r; // capture d waits for the next counter a tick
    reg pin_s1_r;
    reg pin_s2_r;
    reg filt_prev_r;
    reg [7:0] rd_addr_r;
    reg [7:0] aw_r;
    reg aw_full_r;
    reg [31:0] wd_r;
    reg [3:0] ws_r;
    reg wd_full_r;
    reg ar_take_r;
    wire [7:0] ncnt;
    wire nbusy;
    wire filt;
    wire has_d = (SUBBLOCK >= 12) && (SUBBLOCK <= 15);

    // two-flop synchroniser; only the second stage is read
    always @(posedge core_clk) begin
        if (rst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= first_timer_input;
            pin_s2_r <= pin_s1_r;
        end
    end

    // write channel: address and data latched in either order
    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !wd_full_r && !s_axi_bvalid;
    wire [7:0] wa = aw_full_r ? aw_r : s_axi_awaddr;
    wire [31:0] wdat = wd_full_r ? wd_r : s_axi_wdata;
    wire [3:0] wstb = wd_full_r ? ws_r : s_axi_wstrb;
    wire have_aw = aw_full_r || (s_axi_awvalid && s_axi_awready);
    wire have_w = wd_full_r || (s_axi_wvalid && s_axi_wready);
    wire wr_go = have_aw && have_w;
    wire wr_full = wstb == 4'hf;
    wire wr_known = (wa == `TCNF_OFF_CCA) || (wa == `TCNF_OFF_CCB) || (wa == `TCNF_OFF_CCC)
        || (wa == `TCNF_OFF_CCD && has_d) || (wa == `TCNF_OFF_RDO) || (wa == `TCNF_OFF_NCNT)
        || (wa == `TCNF_OFF_NLIM) || (wa == `TCNF_OFF_CTRL) || (wa == `TCNF_OFF_STAT);
    wire ncnt_wr = wr_go && (wa == `TCNF_OFF_NCNT) && wstb[0]; // byte write

    // filtered input for the edge logic
    assign filtered_input = filt;

    // noise canceller instance; master enable not connected to it
    tcnf_noise_filter #(
        .WIDTH(NC_WIDTH)
    ) u_nf (
        .core_clk(core_clk),
        .rst(rst),
        .pin_sync(pin_s2_r),
        .tick(noise_tick),
        .nce(nce_r),
        .mode_prec(ncm_r), // single shared mode bit
        .limit(nlim_r),
        .cnt_wr(ncnt_wr),
        .cnt_wdata(wdat[7:0]),
        .cnt_r(ncnt),
        .busy_r(nbusy),
        .filt_r(filt)
    );

    // edge of the filtered input, used as the rotation capture trigger
    wire filt_edge = filt != filt_prev_r;
    wire is_pwm = mode_r == `TCNF_MODE_PWM;
    wire is_rot = mode_r == `TCNF_MODE_ROT;
    wire trig_c = (is_pwm && evb_match_b) || (is_rot && filt_edge);
    wire do_c = (ccc_pend_r || trig_c) && tcc_up_tick && (is_pwm || is_rot);
    wire trig_d = has_d && is_rot && filt_edge;
    wire do_d = (ccd_pend_r || trig_d) && tca_up_tick && has_d && is_rot;
    wire cap_evt = cap_a_strobe || cap_b_strobe || do_c || do_d;
    localparam [31:0] RST_A = `TCNF_RST_CCA, RST_C = `TCNF_RST_CCC, RST_D = `TCNF_RST_CCD; // upper 24 bits kept

    // capture, compare and control registers
    always @(posedge core_clk) begin
        if (rst) begin
            cca_r <= RST_A[31:8];
            ccb_r <= `TCNF_RST_CCB;
            ccc_r <= RST_C[31:8];
            ccd_r <= RST_D[31:8];
            rdo_live_r <= 1'b0;
            nlim_r <= `TCNF_RST_NLIM;
            mode_r <= `TCNF_MODE_EDGE;
            nce_r <= 1'b0;
            ncm_r <= 1'b0;
            timer_master_enable <= 1'b0;
            ccc_pend_r <= 1'b0;
            ccd_pend_r <= 1'b0;
            filt_prev_r <= 1'b0;
            input_capture_flag <= 1'b0;
        end else begin
            filt_prev_r <= filt;
            // capture triggers wait for their counter tick
            if (do_c || !(is_pwm || is_rot)) begin
                ccc_pend_r <= 1'b0;
            end else if (trig_c) begin
                ccc_pend_r <= 1'b1;
            end
            if (do_d || !is_rot) begin
                ccd_pend_r <= 1'b0;
            end else if (trig_d) begin
                ccd_pend_r <= 1'b1;
            end
            // software writes need a full longword, except reg b (low two bytes) and byte registers
            if (wr_go && wr_full) begin
                case (wa)
                    `TCNF_OFF_CCA: cca_r <= wdat[31:8];
                    `TCNF_OFF_CCC: ccc_r <= wdat[31:8];
                    `TCNF_OFF_CCD: ccd_r <= wdat[31:8];
                    default: begin
                    end
                endcase
            end
            if (wr_go && (wa == `TCNF_OFF_CCB) && (wstb[1:0] == 2'b11)) begin
                ccb_r <= wdat[15:0];
            end
            if (wr_go && (wa == `TCNF_OFF_NLIM) && wstb[0]) begin
                nlim_r <= wdat[7:0];
            end
            if (wr_go && (wa == `TCNF_OFF_CTRL) && wstb[0]) begin
                mode_r <= wdat[`TCNF_CTRL_MODE_MSB:`TCNF_CTRL_MODE_LSB];
                nce_r <= wdat[`TCNF_CTRL_NCE];
                ncm_r <= wdat[`TCNF_CTRL_NCM];
                timer_master_enable <= wdat[`TCNF_CTRL_MEN];
            end
            // hardware captures override a same-cycle software write
            if (cap_a_strobe) begin
                cca_r <= time_counter_a;
            end
            if (cap_b_strobe) begin
                ccb_r <= edge_event_counter;
            end
            if (do_c) begin
                ccc_r <= time_counter_c;
            end
            if (do_d) begin
                ccd_r <= time_counter_c;
            end
            if (cap_evt || wr_go) begin
                rdo_live_r <= 1'b1;
            end
            // flag: capture sets, dma readout or software zero clears; set wins
            if (cap_evt) begin
                input_capture_flag <= 1'b1;
            end else if (dma_readout_rd) begin
                input_capture_flag <= 1'b0;
            end else if (wr_go && (wa == `TCNF_OFF_STAT) && wstb[0] && !wdat[`TCNF_STAT_ICF]) begin
                input_capture_flag <= 1'b0;
            end
        end
    end

    // readout source by mode; writes to it fall through unstored
    reg [31:0] rdo_val;
    always @* begin
        case (mode_r)
            `TCNF_MODE_EDGE, `TCNF_MODE_UPDN, `TCNF_MODE_QUAD: begin
                rdo_val = {ccb_r, 16'h0000};
            end
            `TCNF_MODE_ROT: begin
                rdo_val = {edge_event_counter, 16'h0000};
            end
            default: begin
                rdo_val = {cca_r, 8'h00};
            end
        endcase
        if (!rdo_live_r) begin
            rdo_val = `TCNF_RST_RDO;
        end
    end

    // write response: okay for mapped addresses, slverr otherwise
    always @(posedge core_clk) begin
        if (rst) begin
            aw_full_r <= 1'b0;
            wd_full_r <= 1'b0;
            aw_r <= 8'h00;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCNF_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !wr_go) begin
                aw_full_r <= 1'b1;
                aw_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_go) begin
                wd_full_r <= 1'b1;
                wd_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_r <= 1'b0;
                wd_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `TCNF_RESP_OKAY : `TCNF_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one read in flight, answered two cycles after acceptance
    assign s_axi_arready = !s_axi_rvalid && !ar_take_r;
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (rd_addr_r)
            `TCNF_OFF_CCA: rd_mux = {cca_r, 8'h00};
            `TCNF_OFF_CCB: rd_mux = {16'h0000, ccb_r};
            `TCNF_OFF_CCC: rd_mux = {ccc_r, 8'h00};
            `TCNF_OFF_CCD: begin
                rd_mux = has_d ? {ccd_r, 8'h00} : 32'h0000_0000;
                rd_ok = has_d;
            end
            `TCNF_OFF_RDO: rd_mux = rdo_val;
            `TCNF_OFF_NCNT: rd_mux = {24'h00_0000, ncnt};
            `TCNF_OFF_NLIM: rd_mux = {24'h00_0000, nlim_r};
            `TCNF_OFF_CTRL: rd_mux = {25'h000_0000, timer_master_enable, ncm_r, nce_r, 1'b0, mode_r};
            `TCNF_OFF_STAT: rd_mux = {29'h0000_0000, nbusy, filt, input_capture_flag};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // read data registered from the mux
    always @(posedge core_clk) begin
        if (rst) begin
            ar_take_r <= 1'b0;
            rd_addr_r <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TCNF_RESP_OKAY;
        end else begin
            ar_take_r <= s_axi_arvalid && s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_addr_r <= s_axi_araddr;
            end
            if (ar_take_r) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `TCNF_RESP_OKAY : `TCNF_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: tcnf_checker.sv
/* checker for tcnf_capture: bus timing, low bytes, flag, filter.
   assumes: aw and w offered together, one read in flight. */
`timescale 1ns/1ps
`default_nettype none
`include "tcnf_map.vh"
module tcnf_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic first_timer_input,
    input wire logic cap_a_strobe,
    input wire logic dma_readout_rd,
    input wire logic filtered_input,
    input wire logic input_capture_flag,
    input wire logic timer_master_enable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic [6:0] ctrl_r; // control bits seen on the bus
    logic [7:0] rd_addr_r; // address of the read in flight
    logic pin_d_r = 1'b0; // pin one cycle back
    logic [3:0] pin_age_r = 4'h0; // cycles the pin stood still, saturating
    wire ctrl_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `TCNF_OFF_CTRL;
    // shadow state follows the bus and the pin
    always @(posedge core_clk) begin
        pin_d_r <= first_timer_input;
        pin_age_r <= (first_timer_input != pin_d_r) ? 4'h0 : pin_age_r + {3'h0, pin_age_r != 4'hf};
        if (rst) begin
            ctrl_r <= 7'h00;
        end else if (ctrl_wr) begin
            ctrl_r <= s_axi_wdata[6:0];
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_r <= s_axi_araddr;
        end
    end
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !s_axi_bvalid && !s_axi_rvalid && !input_capture_flag && !filtered_input)
        else $error("outputs busy after reset");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read data late");
    chk_low_byte: assert property (
        s_axi_rvalid && rd_addr_r inside {8'h00, 8'h08, 8'h0c, 8'h10} |-> s_axi_rdata[7:0] == 8'h00)
        else $error("low byte not zero");
    chk_rdo_half: assert property (
        s_axi_rvalid && rd_addr_r == `TCNF_OFF_RDO && !(ctrl_r[2:0] inside {[3'd1:3'd4]})
        |-> s_axi_rdata[15:0] == 16'h0000) else $error("readout low half set");
    chk_dma_clear: assert property (
        dma_readout_rd && !cap_a_strobe |=> !input_capture_flag)
        else $error("dma did not clear flag");
    chk_men_reg: assert property (ctrl_wr |=> timer_master_enable == ctrl_r[6])
        else $error("master enable wrong");
    chk_sub_hold: assert property (
        ctrl_r[4] && !ctrl_r[5] && $changed(filtered_input) |=> $stable(filtered_input) [*4])
        else $error("subsequent output not masked");
    chk_prec_settle: assert property (
        ctrl_r[4] && ctrl_r[5] && $changed(filtered_input)
        |-> pin_age_r >= 4'h4 && filtered_input == first_timer_input)
        else $error("preceding output unsettled");
    cov_ctrl: cover property (ctrl_wr && s_axi_wdata[4]);
    cov_dma: cover property (dma_readout_rd && input_capture_flag);
    cov_prec: cover property (ctrl_r[5] && $changed(filtered_input));
endmodule
bind tcnf_capture tcnf_checker u_chk (.*);
`default_nettype wire

// File: tcnf_map.vh
/*
 * register offsets, field positions, reset values and mode codes of the
 * timer capture and noise filter subblock.
 * assumes: included by bare name from the design files of this block.
 */
`ifndef TCNF_MAP_VH
`define TCNF_MAP_VH

// register byte offsets on the 32-bit register bus
`define TCNF_OFF_CCA 8'h00
`define TCNF_OFF_CCB 8'h04
`define TCNF_OFF_CCC 8'h08
`define TCNF_OFF_CCD 8'h0c
`define TCNF_OFF_RDO 8'h10
`define TCNF_OFF_NCNT 8'h14
`define TCNF_OFF_NLIM 8'h18
`define TCNF_OFF_CTRL 8'h1c
`define TCNF_OFF_STAT 8'h20

// reset values
`define TCNF_RST_CCA 32'hffff_ff00
`define TCNF_RST_CCB 16'hffff
`define TCNF_RST_CCC 32'hffff_ff00
`define TCNF_RST_CCD 32'hffff_ff00
`define TCNF_RST_RDO 32'hffff_0000
`define TCNF_RST_NCNT 8'h00
`define TCNF_RST_NLIM 8'h00
`define TCNF_LOW_MASK 32'hffff_ff00

// control register fields
`define TCNF_CTRL_MODE_LSB 0
`define TCNF_CTRL_MODE_MSB 2
`define TCNF_CTRL_NCE 4
`define TCNF_CTRL_NCM 5
`define TCNF_CTRL_MEN 6

// status register fields
`define TCNF_STAT_ICF 0
`define TCNF_STAT_FILT 1
`define TCNF_STAT_BUSY 2

// operation modes
`define TCNF_MODE_EDGE 3'd0
`define TCNF_MODE_INTV 3'd1
`define TCNF_MODE_HIGH 3'd2
`define TCNF_MODE_LOW 3'd3
`define TCNF_MODE_PWM 3'd4
`define TCNF_MODE_ROT 3'd5
`define TCNF_MODE_UPDN 3'd6
`define TCNF_MODE_QUAD 3'd7

// axi responses
`define TCNF_RESP_OKAY 2'b00
`define TCNF_RESP_SLVERR 2'b10

`endif

// File: tcnf_noise_filter.v
/*
 * noise canceller for the first timer input: an 8-bit counter clocked by
 * prescaled ticks, subsequent-edge and preceding-edge cancel modes.
 * assumes: pin_sync is already synchronised to core_clk; tick is a
 * one-cycle pulse on core_clk; software counter writes come as a strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module tcnf_noise_filter #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire rst,
    input wire pin_sync,
    input wire tick,
    input wire nce,
    input wire mode_prec,
    input wire [WIDTH-1:0] limit,
    input wire cnt_wr,
    input wire [WIDTH-1:0] cnt_wdata,
    output reg [WIDTH-1:0] cnt_r,
    output reg busy_r,
    output reg filt_r
);
    reg start_lvl_r; // level sampled when the run began
    reg prev_r; // last pin level, for change detection
    reg [WIDTH-1:0] cnt_nxt;
    reg busy_nxt;
    reg filt_nxt;
    wire change = pin_sync != prev_r;
    wire match = busy_r && (cnt_r == limit);

    // next state of the counter and filtered level
    always @* begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        filt_nxt = filt_r;
        if (!busy_r) begin
            if (nce && change) begin
                busy_nxt = 1'b1;
                cnt_nxt = {WIDTH{1'b0}};
                // subsequent-edge passes the starting change at once
                if (!mode_prec) begin
                    filt_nxt = pin_sync;
                end
            end else if (!nce) begin
                filt_nxt = pin_sync; // filter bypassed, raw level passes
            end
        end else if (match) begin
            // stop and clear on the next clock after the match
            busy_nxt = 1'b0;
            cnt_nxt = {WIDTH{1'b0}};
            if (mode_prec) begin
                filt_nxt = start_lvl_r;
            end
        end else if (mode_prec && change) begin
            // early stop, output left unchanged
            busy_nxt = 1'b0;
            cnt_nxt = {WIDTH{1'b0}};
        end else if (tick) begin
            // nce is not looked at while busy, so clearing it continues
            cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
        if (cnt_wr) begin
            cnt_nxt = cnt_wdata;
        end
    end

    // state registers
    always @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= {WIDTH{1'b0}};
            busy_r <= 1'b0;
            filt_r <= 1'b0;
            prev_r <= 1'b0;
            start_lvl_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            filt_r <= filt_nxt;
            prev_r <= pin_sync;
            if (!busy_r) begin
                start_lvl_r <= pin_sync;
            end
        end
    end
endmodule
`default_nettype wire

// File: tcnf_pin_src.sv
/* external pulse source on the first timer input.
   assumes: go lasts one cycle; len 0 is a lasting change, else a glitch. */
`timescale 1ns/1ps
`default_nettype none
module tcnf_pin_src (
    input wire logic core_clk,
    input wire logic go,
    input wire logic lvl,
    input wire logic [7:0] len,
    output logic pin
);
    logic [7:0] left_r = 8'h00; // glitch cycles still to run
    initial pin = 1'b0;
    // pin moves off the edge, like an async source
    always @(posedge core_clk) begin
        if (go) begin
            pin <= #1.7 lvl;
            left_r <= len;
        end else if (left_r == 8'h01) begin
            pin <= #1.7 ~pin;
            left_r <= 8'h00;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: timer_capture_noise_filter_test.sv
/* bench for tcnf_capture: registers, captures, noise filter.
   assumes: checker bound in its own file; pin from tcnf_pin_src. */
`timescale 1ns/1ps
`default_nettype none
`include "tcnf_map.vh"
module timer_capture_noise_filter_test;
    logic core_clk = 1'b0; // 200 mhz
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf; // full words
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic noise_tick = 1'b0; // prescaled tick every other cycle
    logic [23:0] time_counter_a = 24'h13_579b, time_counter_c = 24'h24_68ac;
    logic [15:0] edge_event_counter = 16'h3c5a;
    logic [5:0] strb = 6'h00; // one-cycle timer strobes
    wire cap_a_strobe = strb[0];
    wire cap_b_strobe = strb[1];
    wire evb_match_b = strb[2];
    wire tcc_up_tick = strb[3];
    wire tca_up_tick = strb[4];
    wire dma_readout_rd = strb[5];
    logic pin_go = 1'b0, pin_lvl = 1'b0;
    logic [7:0] pin_len = 8'h00;
    wire first_timer_input;
    logic filtered_input, input_capture_flag, timer_master_enable;
    int error_cnt = 0, compares = 0;
    tcnf_capture #(.SUBBLOCK(12), .NC_WIDTH(8)) dut (.*);
    tcnf_pin_src u_src (.core_clk, .go(pin_go), .lvl(pin_lvl), .len(pin_len), .pin(first_timer_input));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        noise_tick <= ~noise_tick;
    end
    task automatic results;
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: aw and w offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, d, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge core_clk);
        strb[i] <= 1'b1;
        @(posedge core_clk);
        strb[i] <= 1'b0;
    endtask
    // len 0 moves the pin for good, otherwise a glitch of len cycles
    task automatic pin_move(input logic l, input logic [7:0] n);
        @(posedge core_clk);
        pin_go <= 1'b1;
        pin_lvl <= l;
        pin_len <= n;
        @(posedge core_clk);
        pin_go <= 1'b0;
    endtask
    task automatic t_reset;
        rdchk(`TCNF_OFF_CCA, `TCNF_RST_CCA, "reg a reset");
        rdchk(`TCNF_OFF_CCB, {16'h0000, `TCNF_RST_CCB}, "reg b reset");
        rdchk(`TCNF_OFF_CCC, `TCNF_RST_CCC, "reg c reset");
        rdchk(`TCNF_OFF_CCD, `TCNF_RST_CCD, "reg d reset");
        rdchk(`TCNF_OFF_RDO, `TCNF_RST_RDO, "readout reset");
        rdchk(`TCNF_OFF_NCNT, 32'h0, "noise count reset");
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        wr(`TCNF_OFF_CCA, 32'h1234_56ff, r); // nonzero compare value
        rdchk(`TCNF_OFF_CCA, 32'h1234_5600, "reg a");
        wr(`TCNF_OFF_CCB, 32'h0000_abcd, r); // nonzero compare value
        rdchk(`TCNF_OFF_CCB, 32'h0000_abcd, "reg b");
        wr(`TCNF_OFF_RDO, 32'h5555_5555, r);
        chk("readout write resp", 32'(r), 32'(`TCNF_RESP_OKAY));
        rdchk(`TCNF_OFF_RDO, 32'habcd_0000, "readout after write");
        rd(8'h40, d, r);
        chk("unmapped resp", 32'(r), 32'(`TCNF_RESP_SLVERR));
        chk("unmapped data", d, 32'h0);
        wr(`TCNF_OFF_NCNT, 32'h0000_005a, r);
        rdchk(`TCNF_OFF_NCNT, 32'h0000_005a, "noise count write");
        wr(`TCNF_OFF_NCNT, 32'h0, r);
    endtask
    task automatic t_readout;
        logic [31:0] exp_v [8];
        logic [1:0] r;
        exp_v = '{32'habcd_0000, 32'h1234_5600, 32'h1234_5600, 32'h1234_5600, 32'h1234_5600,
            {edge_event_counter, 16'h0000}, 32'habcd_0000, 32'habcd_0000};
        for (int m = 0; m < 8; m++) begin
            wr(`TCNF_OFF_CTRL, 32'(m), r);
            rdchk(`TCNF_OFF_RDO, exp_v[m], "readout source");
        end
    endtask
    task automatic t_capture;
        logic [1:0] r;
        wr(`TCNF_OFF_CTRL, 32'h0000_0040, r);
        chk("master enable", 32'(timer_master_enable), 32'h1);
        pulse(2);
        pulse(3);
        rdchk(`TCNF_OFF_CCC, `TCNF_RST_CCC, "no capture c in edge mode");
        wr(`TCNF_OFF_CTRL, 32'h0000_0044, r);
        pulse(2);
        pulse(3);
        rdchk(`TCNF_OFF_CCC, {time_counter_c, 8'h00}, "capture c pwm");
        time_counter_c <= 24'h0a_bcde;
        wr(`TCNF_OFF_CTRL, 32'h0000_0045, r);
        pin_move(1'b1, 8'h00);
        repeat (8) @(posedge core_clk);
        pulse(3);
        rdchk(`TCNF_OFF_CCC, 32'h0abc_de00, "capture c rotation");
        pin_move(1'b0, 8'h00);
        repeat (8) @(posedge core_clk);
        pulse(4);
        rdchk(`TCNF_OFF_CCD, 32'h0abc_de00, "capture d rotation");
        wr(`TCNF_OFF_CTRL, 32'h0000_0040, r);
        pulse(1);
        rdchk(`TCNF_OFF_CCB, {16'h0000, edge_event_counter}, "capture b");
        pulse(0);
        rdchk(`TCNF_OFF_CCA, {time_counter_a, 8'h00}, "capture a");
        chk("flag set", 32'(input_capture_flag), 32'h1);
        pulse(5);
        repeat (2) @(posedge core_clk);
        chk("flag dma clear", 32'(input_capture_flag), 32'h0);
        pulse(0);
        wr(`TCNF_OFF_STAT, 32'h0, r);
        chk("flag sw clear", 32'(input_capture_flag), 32'h0);
    endtask
    task automatic t_sub;
        logic [31:0] d;
        logic [1:0] r;
        wr(`TCNF_OFF_NLIM, 32'h0000_0014, r); // twenty ticks
        wr(`TCNF_OFF_CTRL, 32'h0000_0010, r);
        pin_move(1'b1, 8'h00);
        repeat (6) @(posedge core_clk);
        chk("sub edge passed", 32'(filtered_input), 32'h1);
        rd(`TCNF_OFF_STAT, d, r);
        chk("sub busy", 32'(d[`TCNF_STAT_BUSY]), 32'h1);
        wr(`TCNF_OFF_CTRL, 32'h0, r); // enable dropped mid-count
        pin_move(1'b0, 8'h00);
        repeat (6) @(posedge core_clk);
        chk("sub masked", 32'(filtered_input), 32'h1);
        repeat (60) @(posedge core_clk);
        chk("sub after match", 32'(filtered_input), 32'h0);
        rdchk(`TCNF_OFF_NCNT, 32'h0, "sub count cleared");
    endtask
    task automatic t_prec;
        logic [1:0] r;
        wr(`TCNF_OFF_CTRL, 32'h0000_0030, r);
        pin_move(1'b1, 8'h06);
        repeat (12) @(posedge core_clk);
        chk("prec glitch", 32'(filtered_input), 32'h0);
        rdchk(`TCNF_OFF_NCNT, 32'h0, "prec stop on change");
        pin_move(1'b1, 8'h00);
        repeat (60) @(posedge core_clk);
        chk("prec match", 32'(filtered_input), 32'h1);
        pin_move(1'b0, 8'h00);
        repeat (10) @(posedge core_clk);
        wr(`TCNF_OFF_CTRL, 32'h0000_0020, r); // enable dropped mid-count
        chk("prec held", 32'(filtered_input), 32'h1);
        repeat (60) @(posedge core_clk);
        chk("prec late match", 32'(filtered_input), 32'h0);
    endtask
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        results;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_readout;
        t_capture;
        t_sub;
        t_prec;
        results;
    end
endmodule
`default_nettype wire
